// ### logic/frs_params.svh
`ifndef FRS_PARAMS_SVH
`define FRS_PARAMS_SVH

// register port geometry
`define FRS_DATA_W 30
`define FRS_ADDR_W 5
`define FRS_DEPTH 32
`define FRS_WORD_ZERO 30'h0

// register offsets
`define FRS_REG_GPIO_EN 5'h01
`define FRS_REG_START_INT 5'h05
`define FRS_REG_FRAC_HI 5'h06
`define FRS_REG_FRAC_LO 5'h07
`define FRS_REG_GPIO_CFG 5'h08
`define FRS_REG_SEED_HI 5'h0A
`define FRS_REG_SEED_LO 5'h0B
`define FRS_REG_DNCNT_HI 5'h0C
`define FRS_REG_DNCNT_LO 5'h0D
`define FRS_REG_CTRL 5'h0E
`define FRS_REG_DWELL_HI 5'h10
`define FRS_REG_DWELL_LO 5'h11
`define FRS_REG_STEP_HI 5'h12
`define FRS_REG_STEP_LO 5'h13
`define FRS_REG_CNT_HI 5'h14
`define FRS_REG_CNT_LO 5'h15
`define FRS_REG_STATUS 5'h1F

// field positions
`define FRS_BIT_GPIO_MASTER 4
`define FRS_BIT_PIN_FUNC 13
`define FRS_BIT_AUTO_LO 2
`define FRS_BIT_AUTO_HI 3
`define FRS_BIT_TRIG_DLY 7
`define FRS_BIT_AUTOSEED 8
`define FRS_BIT_SWEEP_EN 11
`define FRS_BIT_SPI_TRIG 12
`define FRS_BIT_TRIG_SRC 13
`define FRS_BIT_SYMM 22
`define FRS_BIT_SINGLE 24
`define FRS_BIT_ONEWAY 25
`define FRS_BIT_DIR_UP 26

// value widths
`define FRS_LO_W 18
`define FRS_VAL_W 48
`define FRS_INT_W 21
`define FRS_DLY_ZERO 21'h0
`define FRS_DLY_ONE 21'h1
`define FRS_CNT_ZERO 48'h0
`define FRS_CNT_ONE 48'h1
`define FRS_DIV_ZERO 69'h0

// divided reference: system clocks per reference period
`define FRS_REF_DIV 8'h01
`define FRS_REF_ZERO 8'h00
`define FRS_REF_ONE 8'h01

`endif

// ### logic/frs_pkg.sv
`include "frs_params.svh"

package frs_pkg;

	typedef logic [`FRS_DATA_W-1:0] frs_word_t;
	typedef logic [`FRS_ADDR_W-1:0] frs_addr_t;
	typedef logic [`FRS_VAL_W-1:0] frs_val_t;
	typedef logic [`FRS_INT_W-1:0] frs_int_t;
	typedef logic [`FRS_INT_W+`FRS_VAL_W-1:0] frs_div_t;

	typedef enum logic [1:0] {
		FRS_IDLE = 2'b00,
		FRS_RAMP = 2'b01,
		FRS_DWELL = 2'b10,
		FRS_END = 2'b11
	} frs_state_e;

	// 48-bit value from a 30-bit upper and 18-bit lower word
	function automatic frs_val_t frsJoin(frs_word_t hi, frs_word_t lo);
		return {hi, lo[`FRS_LO_W-1:0]};
	endfunction

	// one increment of the divider setting, either direction
	function automatic frs_div_t frsStep(frs_div_t cur, frs_val_t step,
			logic up);
		frs_div_t wide;
		wide = {{`FRS_INT_W{1'b0}}, step};
		return up ? cur + wide : cur - wide;
	endfunction

	// true when the count being finished is the last one
	function automatic logic frsLast(frs_val_t cnt, frs_val_t lim);
		frs_val_t nxt;
		nxt = cnt + `FRS_CNT_ONE;
		return nxt >= lim;
	endfunction

endpackage

// ### logic/frs_reg_mem.sv
`timescale 1ns/1ps
`include "frs_params.svh"

module frs_reg_mem (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic wrEn,
	input wire frs_pkg::frs_addr_t wrAddr,
	input wire frs_pkg::frs_word_t wrData,
	input wire logic rdEn,
	input wire frs_pkg::frs_addr_t rdAddr,
	output frs_pkg::frs_word_t rdData
);
	import frs_pkg::*;

	frs_word_t mem [0:`FRS_DEPTH-1];
	frs_word_t next_rdData;

	// readback copy only; no reset, so unwritten words read unknown
	always_ff @(posedge ref_clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	// registered read port
	always_comb begin
		next_rdData = rdData;
		if (rdEn) begin
			next_rdData = mem[rdAddr];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData <= `FRS_WORD_ZERO;
		end else begin
			rdData <= next_rdData;
		end
	end

endmodule

// ### logic/frs_sweeper.sv
`timescale 1ns/1ps
`include "frs_params.svh"

// Operation
// (R1) host loads start integer, fraction and optional seed; sweep starts there
// (R2) sweeping only while the sweep-mode control bit is one
// (R3) single-step bit zero: increments advance by themselves
// (R4) single-step bit one: exactly one increment per trigger
// (R5) shape bit zero two-way, one one-way
// (R6) mode field 11 automatic with internal triggers, 00 triggered
// (R7) host uses triggered operation with user-defined sweeps
// (R8) host uses triggered operation for automatic-step one-way sweeps
// (R9) direction bit one starts upward, zero downward
// (R10) symmetric: up dwell, step size and count serve both directions
// (R11) symmetric ramps mirror each other, differing only in direction
// (R12) host sets symmetric mode for one-way sweeps
// (R13) up values are 48 bits: 30 upper, 18 lower
// (R14) asymmetric down step count is 48 bits from a register pair
// (R15) trigger source bit: zero serial-port write, one external pin
// (R16) host sets pin function to input for external triggers
// (R17) external triggers need the GPIO master enable set
// (R18) delay bit one postpones each trigger by the programmed delay; a trigger arriving while a delay is running is dropped
// (R19) delay is the 21-bit field in divided reference periods
// (R20) ramp-active flag high from first through last increment
// (R21) external trigger taken on the pin's rising edge
// (R22) user one-way: trigger n+1 returns to start, n+2 restarts
// (R23) automatic seed reloads the seed at every ramp start
// (R24) automatic stepping adds one step per reference period, then dwells
// (R25) serial trigger accepted anytime, acted on at next reference tick
module frs_sweeper (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic regWrEn,
	input wire frs_pkg::frs_addr_t regAddr,
	input wire frs_pkg::frs_word_t regWrData,
	input wire logic regRdEn,
	input wire logic externalTriggerPin,
	output frs_pkg::frs_word_t regRdData,
	output logic regRdValid,
	output frs_pkg::frs_int_t divInt,
	output frs_pkg::frs_val_t divFrac,
	output logic sweepOn,
	output logic rampBusy,
	output logic rampUp,
	output logic seedLoad,
	output frs_pkg::frs_val_t seedValue
);
	import frs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// configuration registers

	frs_word_t gpioEn, startInt, fracHi, fracLo, pinCfg, seedHi, seedLo;
	frs_word_t dnCntHi, dnCntLo, ctrl, dwellHi, dwellLo, stepHi, stepLo;
	frs_word_t cntHi, cntLo;
	frs_word_t next_gpioEn, next_startInt, next_fracHi, next_fracLo;
	frs_word_t next_pinCfg, next_seedHi, next_seedLo, next_dnCntHi;
	frs_word_t next_dnCntLo, next_ctrl, next_dwellHi, next_dwellLo;
	frs_word_t next_stepHi, next_stepLo, next_cntHi, next_cntLo;
	frs_word_t wrMasked;
	logic ctrlWr;

	assign ctrlWr = regWrEn && (regAddr == `FRS_REG_CTRL);
	// the serial trigger bit is a strobe and is never stored
	assign wrMasked = ctrlWr ?
		(regWrData & ~(`FRS_DATA_W'(1) << `FRS_BIT_SPI_TRIG)) : regWrData;

	// address decode for writes; unmapped addresses only reach readback
	always_comb begin
		next_gpioEn = gpioEn;
		next_startInt = startInt;
		next_fracHi = fracHi;
		next_fracLo = fracLo;
		next_pinCfg = pinCfg;
		next_seedHi = seedHi;
		next_seedLo = seedLo;
		next_dnCntHi = dnCntHi;
		next_dnCntLo = dnCntLo;
		next_ctrl = ctrl;
		next_dwellHi = dwellHi;
		next_dwellLo = dwellLo;
		next_stepHi = stepHi;
		next_stepLo = stepLo;
		next_cntHi = cntHi;
		next_cntLo = cntLo;
		if (regWrEn) begin
			unique case (regAddr)
				`FRS_REG_GPIO_EN: next_gpioEn = wrMasked;
				`FRS_REG_START_INT: next_startInt = wrMasked;
				`FRS_REG_FRAC_HI: next_fracHi = wrMasked;
				`FRS_REG_FRAC_LO: next_fracLo = wrMasked;
				`FRS_REG_GPIO_CFG: next_pinCfg = wrMasked;
				`FRS_REG_SEED_HI: next_seedHi = wrMasked;
				`FRS_REG_SEED_LO: next_seedLo = wrMasked;
				`FRS_REG_DNCNT_HI: next_dnCntHi = wrMasked;
				`FRS_REG_DNCNT_LO: next_dnCntLo = wrMasked;
				`FRS_REG_CTRL: next_ctrl = wrMasked;
				`FRS_REG_DWELL_HI: next_dwellHi = wrMasked;
				`FRS_REG_DWELL_LO: next_dwellLo = wrMasked;
				`FRS_REG_STEP_HI: next_stepHi = wrMasked;
				`FRS_REG_STEP_LO: next_stepLo = wrMasked;
				`FRS_REG_CNT_HI: next_cntHi = wrMasked;
				`FRS_REG_CNT_LO: next_cntLo = wrMasked;
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			gpioEn <= `FRS_WORD_ZERO;
			startInt <= `FRS_WORD_ZERO;
			fracHi <= `FRS_WORD_ZERO;
			fracLo <= `FRS_WORD_ZERO;
			pinCfg <= `FRS_WORD_ZERO;
			seedHi <= `FRS_WORD_ZERO;
			seedLo <= `FRS_WORD_ZERO;
			dnCntHi <= `FRS_WORD_ZERO;
			dnCntLo <= `FRS_WORD_ZERO;
			ctrl <= `FRS_WORD_ZERO;
			dwellHi <= `FRS_WORD_ZERO;
			dwellLo <= `FRS_WORD_ZERO;
			stepHi <= `FRS_WORD_ZERO;
			stepLo <= `FRS_WORD_ZERO;
			cntHi <= `FRS_WORD_ZERO;
			cntLo <= `FRS_WORD_ZERO;
		end else begin
			gpioEn <= next_gpioEn;
			startInt <= next_startInt;
			fracHi <= next_fracHi;
			fracLo <= next_fracLo;
			pinCfg <= next_pinCfg;
			seedHi <= next_seedHi;
			seedLo <= next_seedLo;
			dnCntHi <= next_dnCntHi;
			dnCntLo <= next_dnCntLo;
			ctrl <= next_ctrl;
			dwellHi <= next_dwellHi;
			dwellLo <= next_dwellLo;
			stepHi <= next_stepHi;
			stepLo <= next_stepLo;
			cntHi <= next_cntHi;
			cntLo <= next_cntLo;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// decoded sweep parameters

	frs_val_t upDwell, upStep, upCount, dnCount, rampCount;
	frs_div_t startSetting;
	logic autoMode, single, oneWay, symm, dirStart, dlyEn;
	frs_int_t dlyLen;

	// (R13) 48-bit up values
	assign upDwell = frsJoin(dwellHi, dwellLo);
	assign upStep = frsJoin(stepHi, stepLo);
	assign upCount = frsJoin(cntHi, cntLo);
	// (R14) asymmetric down count
	assign dnCount = frsJoin(dnCntHi, dnCntLo);
	// (R1) sweep origin
	assign startSetting = {startInt[`FRS_INT_W-1:0], frsJoin(fracHi, fracLo)};
	// (R6) mode field decode
	assign autoMode = ctrl[`FRS_BIT_AUTO_LO] && ctrl[`FRS_BIT_AUTO_HI];
	assign single = ctrl[`FRS_BIT_SINGLE];
	assign oneWay = ctrl[`FRS_BIT_ONEWAY];
	assign symm = ctrl[`FRS_BIT_SYMM];
	assign dirStart = ctrl[`FRS_BIT_DIR_UP];
	assign dlyEn = ctrl[`FRS_BIT_TRIG_DLY];
	// (R19) delay field shares the start-integer word
	assign dlyLen = startInt[`FRS_INT_W-1:0];

	////////////////////////////////////////////////////////////////////////
	// reference tick and trigger path

	logic [7:0] refCnt, next_refCnt;
	logic refTick, pinPrev, trigPend, next_trigPend, dlyArmed, next_dlyArmed;
	logic extEdge, extOk, spiTrig, newTrig, take, fire;
	frs_int_t dlyCnt, next_dlyCnt;

	assign refTick = (refCnt == `FRS_REF_DIV - `FRS_REF_ONE);
	// (R21) rising edge of the trigger pin
	assign extEdge = externalTriggerPin && !pinPrev;
	// (R17) pin path also needs master enable and input function
	assign extOk = gpioEn[`FRS_BIT_GPIO_MASTER] && !pinCfg[`FRS_BIT_PIN_FUNC];
	assign spiTrig = ctrlWr && regWrData[`FRS_BIT_SPI_TRIG];
	// (R15) pick the trigger source
	assign newTrig = ctrl[`FRS_BIT_TRIG_SRC] ? (extEdge && extOk) : spiTrig;
	assign take = trigPend && refTick;
	// (R18) delayed or direct trigger
	assign fire = dlyEn ?
		((dlyArmed && refTick && (dlyCnt <= `FRS_DLY_ONE)) ||
		(take && !dlyArmed && (dlyLen == `FRS_DLY_ZERO))) : take;

	// pending trigger waits for the reference tick; a new one wins a clear
	always_comb begin
		next_refCnt = refTick ? `FRS_REF_ZERO : refCnt + `FRS_REF_ONE;
		// (R25) hold a trigger until the next reference tick
		next_trigPend = (trigPend && !refTick) || newTrig;
		next_dlyArmed = dlyArmed;
		next_dlyCnt = dlyCnt;
		// (R19) count the delay in reference periods
		if (!dlyEn) begin
			next_dlyArmed = 1'b0;
		end else if (dlyArmed && refTick) begin
			next_dlyCnt = dlyCnt - `FRS_DLY_ONE;
			next_dlyArmed = (dlyCnt > `FRS_DLY_ONE);
		end else if (take && (dlyLen != `FRS_DLY_ZERO)) begin
			next_dlyCnt = dlyLen;
			next_dlyArmed = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			refCnt <= `FRS_REF_ZERO;
			pinPrev <= 1'b0;
			trigPend <= 1'b0;
			dlyArmed <= 1'b0;
			dlyCnt <= `FRS_DLY_ZERO;
		end else begin
			refCnt <= next_refCnt;
			pinPrev <= externalTriggerPin;
			trigPend <= next_trigPend;
			dlyArmed <= next_dlyArmed;
			dlyCnt <= next_dlyCnt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sweep engine, advances only on reference ticks

	frs_state_e state, next_state;
	frs_div_t cur, next_cur;
	frs_val_t stepCnt, next_stepCnt, dwellCnt, next_dwellCnt;
	logic next_rampBusy, next_rampUp, next_seedLoad, go, adv;

	// (R10) symmetric mode or upward ramps use the up count
	assign rampCount = (symm || rampUp) ? upCount : dnCount;
	// (R6) automatic mode triggers itself
	assign go = autoMode || fire;
	// (R3) self-advance, (R4) one increment per trigger; the trigger that
	// starts a ramp earns its first increment on the following tick
	assign adv = single ? (fire || (stepCnt == `FRS_CNT_ZERO)) : 1'b1;

	always_comb begin
		next_state = state;
		next_cur = cur;
		next_stepCnt = stepCnt;
		next_dwellCnt = dwellCnt;
		next_rampBusy = rampBusy;
		next_rampUp = rampUp;
		next_seedLoad = 1'b0;
		// (R2) no sweep unless the sweep-mode bit is set
		if (!ctrl[`FRS_BIT_SWEEP_EN]) begin
			next_state = FRS_IDLE;
			next_cur = startSetting;
			next_rampBusy = 1'b0;
			next_rampUp = dirStart;
		end else if (refTick) begin
			unique case (state)
				FRS_IDLE: begin
					next_cur = startSetting;
					if (go) begin
						// (R9) initial direction
						next_rampUp = dirStart;
						next_stepCnt = `FRS_CNT_ZERO;
						// (R23) reseed at ramp start
						next_seedLoad = ctrl[`FRS_BIT_AUTOSEED];
						next_state = FRS_RAMP;
					end
				end
				FRS_RAMP: begin
					if (rampCount == `FRS_CNT_ZERO) begin
						next_state = single ? FRS_END : FRS_DWELL;
						next_dwellCnt = `FRS_CNT_ZERO;
					end else if (adv) begin
						// (R24) one step per reference period
						// (R11) same step size in both directions
						next_cur = frsStep(cur, upStep, rampUp);
						next_stepCnt = stepCnt + `FRS_CNT_ONE;
						// (R20) busy from first through last increment
						next_rampBusy = 1'b1;
						if (frsLast(stepCnt, rampCount)) begin
							next_state = single ? FRS_END : FRS_DWELL;
							next_dwellCnt = `FRS_CNT_ZERO;
						end
					end
				end
				FRS_DWELL: begin
					// (R24) dwell after the last step
					next_rampBusy = 1'b0;
					next_dwellCnt = dwellCnt + `FRS_CNT_ONE;
					if (frsLast(dwellCnt, upDwell)) begin
						next_state = FRS_END;
					end
				end
				FRS_END: begin
					next_rampBusy = 1'b0;
					if (oneWay) begin
						// (R22) hop back to start; next trigger restarts
						if (go) begin
							next_cur = startSetting;
							next_state = FRS_IDLE;
						end
					end else if (go) begin
						// (R5) two-way reverses and ramps back
						next_rampUp = !rampUp;
						next_stepCnt = `FRS_CNT_ZERO;
						next_seedLoad = ctrl[`FRS_BIT_AUTOSEED];
						next_state = FRS_RAMP;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= FRS_IDLE;
			cur <= `FRS_DIV_ZERO;
			stepCnt <= `FRS_CNT_ZERO;
			dwellCnt <= `FRS_CNT_ZERO;
			rampBusy <= 1'b0;
			rampUp <= 1'b0;
			seedLoad <= 1'b0;
		end else begin
			state <= next_state;
			cur <= next_cur;
			stepCnt <= next_stepCnt;
			dwellCnt <= next_dwellCnt;
			rampBusy <= next_rampBusy;
			rampUp <= next_rampUp;
			seedLoad <= next_seedLoad;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs and readback

	frs_word_t memRd, statusWord, next_regRdData;
	frs_addr_t rdAddrQ;
	logic rdEnQ, next_sweepOn;
	frs_int_t next_divInt;
	frs_val_t next_divFrac, next_seedValue;

	frs_reg_mem uMem (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wrEn(regWrEn),
		.wrAddr(regAddr),
		.wrData(wrMasked),
		.rdEn(regRdEn),
		.rdAddr(regAddr),
		.rdData(memRd)
	);

	// live status: state, direction, busy, sweep on
	assign statusWord = {{(`FRS_DATA_W - 5){1'b0}}, state, rampUp, rampBusy,
		sweepOn};

	// second read stage keeps every output on a flop
	always_comb begin
		next_regRdData = regRdData;
		if (rdEnQ) begin
			next_regRdData = (rdAddrQ == `FRS_REG_STATUS) ? statusWord : memRd;
		end
		next_sweepOn = ctrl[`FRS_BIT_SWEEP_EN];
		next_divInt = next_cur[`FRS_INT_W+`FRS_VAL_W-1:`FRS_VAL_W];
		next_divFrac = next_cur[`FRS_VAL_W-1:0];
		next_seedValue = frsJoin(seedHi, seedLo);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdEnQ <= 1'b0;
			rdAddrQ <= `FRS_REG_GPIO_EN;
			regRdData <= `FRS_WORD_ZERO;
			regRdValid <= 1'b0;
			sweepOn <= 1'b0;
			divInt <= `FRS_DLY_ZERO;
			divFrac <= `FRS_CNT_ZERO;
			seedValue <= `FRS_CNT_ZERO;
		end else begin
			rdEnQ <= regRdEn;
			rdAddrQ <= regAddr;
			regRdData <= next_regRdData;
			regRdValid <= rdEnQ;
			sweepOn <= next_sweepOn;
			divInt <= next_divInt;
			divFrac <= next_divFrac;
			seedValue <= next_seedValue;
		end
	end

endmodule

// ### tb/frs_sweeper_asserts.sv
`timescale 1ns/1ps
`include "frs_params.svh"

// judges settled outputs against a shadow of what the host wrote
module frs_sweeper_asserts (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic regWrEn,
	input wire frs_pkg::frs_addr_t regAddr,
	input wire frs_pkg::frs_word_t regWrData,
	input wire logic regRdEn,
	input wire frs_pkg::frs_word_t regRdData,
	input wire logic regRdValid,
	input wire frs_pkg::frs_int_t divInt,
	input wire frs_pkg::frs_val_t divFrac,
	input wire logic sweepOn,
	input wire logic rampBusy,
	input wire logic seedLoad,
	input wire frs_pkg::frs_val_t seedValue
);
	import frs_pkg::*;

	frs_word_t shadow [`FRS_DEPTH];
	frs_word_t next_shadow [`FRS_DEPTH];
	logic [`FRS_DEPTH-1:0] wrote;
	logic [`FRS_DEPTH-1:0] next_wrote;
	logic [2:0] quiet;
	logic [2:0] next_quiet;
	frs_word_t ctrl;

	// quiet saturates at five: outputs lag writes by up to three edges
	always_comb begin
		next_shadow = shadow;
		next_wrote = wrote;
		next_quiet = (quiet == 3'h5) ? quiet : quiet + 3'h1;
		if (regWrEn) begin
			next_shadow[regAddr] = regWrData;
			next_wrote[regAddr] = 1'b1;
			next_quiet = 3'h0;
		end
	end

	// shadow registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			shadow <= '{default: '0};
			wrote <= '0;
			quiet <= 3'h0;
		end else begin
			shadow <= next_shadow;
			wrote <= next_wrote;
			quiet <= next_quiet;
		end
	end

	assign ctrl = shadow[`FRS_REG_CTRL];

	////////////////////////////////////////////////////////////
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_read_lat: assert property (regRdEn |-> ##2 regRdValid)
		else $error("read strobe not answered in two cycles");
	a_valid_cause: assert property (regRdValid |-> $past(regRdEn, 2))
		else $error("read valid without strobe");
	a_trig_unkept: assert property (regRdValid &&
		$past(regAddr, 2) == `FRS_REG_CTRL |-> !regRdData[12])
		else $error("trigger bit read back as one");
	a_ctrl_back: assert property (regRdValid && quiet == 3'h5 &&
		$past(regAddr, 2) == `FRS_REG_CTRL |->
		regRdData == {ctrl[29:13], 1'b0, ctrl[11:0]})
		else $error("control readback differs");
	a_sweep_copy: assert property (quiet == 3'h5 |-> sweepOn == ctrl[11])
		else $error("sweep flag differs from control bit");
	a_idle_start: assert property (quiet == 3'h5 && !ctrl[11] &&
		&wrote[7:5] |-> divInt == shadow[5'h05][20:0] &&
		divFrac == {shadow[5'h06], shadow[5'h07][17:0]})
		else $error("idle setting is not the start value");
	a_off_quiet: assert property (quiet == 3'h5 && !ctrl[11] |->
		!rampBusy && !seedLoad)
		else $error("activity while sweep disabled");
	a_seed_out: assert property (quiet == 3'h5 && &wrote[11:10] |->
		seedValue == {shadow[5'h0A], shadow[5'h0B][17:0]})
		else $error("seed value not joined from its pair");
	a_seed_pulse: assert property (seedLoad |-> ctrl[8] ##1 !seedLoad)
		else $error("seed load without autoseed or too long");

	c_ramp: cover property ($rose(rampBusy));
	c_seed: cover property (seedLoad);
	c_read: cover property (regRdValid);
endmodule

bind frs_sweeper frs_sweeper_asserts frs_sweeper_asserts_inst (
	.ref_clk(ref_clk),
	.rst_n(rst_n),
	.regWrEn(regWrEn),
	.regAddr(regAddr),
	.regWrData(regWrData),
	.regRdEn(regRdEn),
	.regRdData(regRdData),
	.regRdValid(regRdValid),
	.divInt(divInt),
	.divFrac(divFrac),
	.sweepOn(sweepOn),
	.rampBusy(rampBusy),
	.seedLoad(seedLoad),
	.seedValue(seedValue)
);

// ### tb/frs_host_model.sv
`timescale 1ns/1ps
`include "frs_params.svh"

// host side: owns the register strobes and the trigger pin
module frs_host_model (
	input wire logic ref_clk,
	input wire frs_pkg::frs_word_t regRdData,
	input wire logic regRdValid,
	output logic regWrEn,
	output frs_pkg::frs_addr_t regAddr,
	output frs_pkg::frs_word_t regWrData,
	output logic regRdEn,
	output logic externalTriggerPin
);
	import frs_pkg::*;

	// everything idle from time zero
	initial begin
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regAddr = '0;
		regWrData = '0;
		externalTriggerPin = 1'b0;
	end

	task automatic wr(input frs_addr_t a, input frs_word_t d);
		@(negedge ref_clk);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(negedge ref_clk);
		regWrEn = 1'b0;
	endtask

	// valid is due two edges after the strobe; four is the bound
	task automatic rd(input frs_addr_t a, output frs_word_t d,
			output logic ok);
		@(negedge ref_clk);
		regAddr = a;
		regRdEn = 1'b1;
		@(negedge ref_clk);
		regRdEn = 1'b0;
		ok = 1'b0;
		d = '0;
		for (int i = 0; i < 4 && !ok; i++) begin
			@(posedge ref_clk);
			#1;
			if (regRdValid === 1'b1) begin
				d = regRdData;
				ok = 1'b1;
			end
		end
	endtask

	task automatic pin(input int hold);
		@(negedge ref_clk);
		externalTriggerPin = 1'b1;
		repeat (hold) @(negedge ref_clk);
		externalTriggerPin = 1'b0;
	endtask
endmodule

// ### tb/frs_sweeper_tb.sv
`timescale 1ns/1ps
`include "frs_params.svh"

module frs_sweeper_tb;
	import frs_pkg::*;

	// start integer 5 doubles as a delay of five ticks
	localparam frs_div_t BASE = {21'h5, 48'h40100};
	localparam frs_div_t STEP = 69'h10;
	localparam frs_addr_t RA [15] = '{5'h05, 5'h06, 5'h07, 5'h0A, 5'h0B,
		5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h0C, 5'h0D, 5'h01, 5'h08};
	localparam frs_word_t RV [15] = '{30'h5, 30'h1, 30'h100, 30'h1, 30'h2,
		30'h0, 30'h2, 30'h0, 30'h10, 30'h0, 30'h3, 30'h0, 30'h2, 30'h0, 30'h0};
	localparam int UD [6] = '{0, 1, 2, 3, 0, 1};

	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic regWrEn, regRdEn, regRdValid, externalTriggerPin;
	logic sweepOn, rampBusy, rampUp, seedLoad, ok;
	logic seedSeen = 1'b0;
	frs_addr_t regAddr;
	frs_word_t regWrData, regRdData, ctrl, rdv;
	frs_int_t divInt;
	frs_val_t divFrac, seedValue;
	int miscompares = 0;
	int checksDone = 0;

	always #12.5 ref_clk = ~ref_clk;

	// remembers that a ramp start reloaded the seed
	always @(posedge ref_clk) if (seedLoad === 1'b1) seedSeen <= 1'b1;

	frs_sweeper frs_sweeper_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData),
		.regRdEn(regRdEn), .externalTriggerPin(externalTriggerPin),
		.regRdData(regRdData), .regRdValid(regRdValid), .divInt(divInt),
		.divFrac(divFrac), .sweepOn(sweepOn), .rampBusy(rampBusy),
		.rampUp(rampUp), .seedLoad(seedLoad), .seedValue(seedValue));
	frs_host_model frs_host_model_inst (.ref_clk(ref_clk),
		.regRdData(regRdData), .regRdValid(regRdValid), .regWrEn(regWrEn),
		.regAddr(regAddr), .regWrData(regWrData), .regRdEn(regRdEn),
		.externalTriggerPin(externalTriggerPin));

	////////////////////////////////////////////////////////////
	task automatic check(input frs_div_t seen, input frs_div_t exp);
		checksDone++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic results();
		if (miscompares == 0 && checksDone > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic wr(input frs_addr_t a, input frs_word_t d);
		frs_host_model_inst.wr(a, d);
	endtask

	task automatic waitBusy(input logic lvl);
		for (int n = 0; n < 300 && rampBusy !== lvl; n++)
			@(negedge ref_clk);
		if (rampBusy !== lvl) begin
			miscompares++;
			results();
		end
	endtask

	// disabling first returns the engine to the start value
	task automatic cfg(input frs_word_t c);
		wr(`FRS_REG_CTRL, 30'h0);
		ctrl = c;
		wr(`FRS_REG_CTRL, c);
		repeat (6) @(negedge ref_clk);
	endtask

	// serial trigger, then the whole ramp and its dwell
	task automatic ramp();
		wr(`FRS_REG_CTRL, ctrl | 30'h1000);
		waitBusy(1'b1);
		waitBusy(1'b0);
		repeat (10) @(negedge ref_clk);
	endtask

	initial begin
		repeat (3) @(negedge ref_clk);
		rst_n = 1'b1;
		for (int i = 0; i < 15; i++) wr(RA[i], RV[i]);
		repeat (6) @(negedge ref_clk);
		check({divInt, divFrac}, BASE);
		check(seedSeen, 1'b0);
		// up first, symmetric, autoseed, triggered
		cfg(30'h4400900);
		repeat (20) @(negedge ref_clk);
		check(rampBusy, 1'b0);
		ramp();
		check({divInt, divFrac}, BASE + STEP * 3);
		check(rampUp, 1'b1);
		check(seedSeen, 1'b1);
		check(seedValue, 48'h40002);
		ramp();
		check({divInt, divFrac}, BASE);
		check(rampUp, 1'b0);
		frs_host_model_inst.rd(`FRS_REG_CTRL, rdv, ok);
		check({ok, rdv}, {1'b1, 30'h4400900});
		// status after a finished ramp: end state, down, not busy, sweep on
		frs_host_model_inst.rd(`FRS_REG_STATUS, rdv, ok);
		check({ok, rdv}, {1'b1, 30'h19});
		// asymmetric: down count is two; then symmetric, starting down
		cfg(30'h4000800);
		ramp();
		ramp();
		check({divInt, divFrac}, BASE + STEP);
		cfg(30'h400800);
		ramp();
		check({divInt, divFrac}, BASE - STEP * 3);
		// one-way with automatic then single steps, triggered; next trigger hops back
		cfg(30'h6400800);
		ramp();
		check({divInt, divFrac}, BASE + STEP * 3);
		wr(`FRS_REG_CTRL, ctrl | 30'h1000);
		repeat (8) @(negedge ref_clk);
		check({divInt, divFrac}, BASE);
		cfg(30'h7400800);
		for (int k = 1; k <= 5; k++) begin
			wr(`FRS_REG_CTRL, ctrl | 30'h1000);
			repeat (8) @(negedge ref_clk);
			check({divInt, divFrac}, BASE + STEP * UD[k]);
		end
		// pin source with delay: serial trigger is not taken
		cfg(30'h5402880);
		wr(`FRS_REG_CTRL, ctrl | 30'h1000);
		repeat (12) @(negedge ref_clk);
		check({divInt, divFrac}, BASE);
		frs_host_model_inst.pin(3);
		repeat (12) @(negedge ref_clk);
		check({divInt, divFrac}, BASE);
		// master enable on, pin stays input
		wr(`FRS_REG_GPIO_EN, 30'h10);
		frs_host_model_inst.pin(3);
		repeat (2) @(negedge ref_clk);
		check({divInt, divFrac}, BASE);
		repeat (10) @(negedge ref_clk);
		check({divInt, divFrac}, BASE + STEP);
		// automatic mode starts on its own
		cfg(30'h440080C);
		waitBusy(1'b1);
		check(rampBusy, 1'b1);
		results();
	end
endmodule
